// ---- gpio_pkg.sv ----
// package: register map, field positions and reset values of the gpio port block
package gpio_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_A_DATA = 8'h00;
  localparam logic [7:0] OFF_A_DIR = 8'h04;
  localparam logic [7:0] OFF_B_DATA = 8'h08;
  localparam logic [7:0] OFF_B_DIR = 8'h0c;
  localparam logic [7:0] OFF_C_DATA = 8'h10;
  localparam logic [7:0] OFF_C_DIR = 8'h14;
  localparam logic [7:0] OFF_D_DATA = 8'h18;
  localparam logic [7:0] OFF_D_DIR = 8'h1c;
  localparam logic [7:0] OFF_F_DATA = 8'h20;
  localparam logic [7:0] OFF_F_DIR = 8'h24;
  localparam logic [7:0] OFF_WAKE_SEL = 8'h28;
  localparam logic [7:0] OFF_ANALOG_SEL = 8'h2c;
  localparam logic [7:0] OFF_BITOP = 8'h30;
  localparam logic [7:0] OFF_CTRL = 8'h34;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h38;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h3c;
  // reset values
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic [7:0] WAKE_RESET = 8'h00;
  localparam logic [15:0] ANALOG_RESET = 16'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // bit-op register fields: [2:0] bit, [6:3] register index, [8] set(1)/clear(0)
  localparam int BITOP_BIT_LSB = 0;
  localparam int BITOP_REG_LSB = 3;
  localparam int BITOP_SET_POS = 8;
  // control register: [0] halt request (write 1)
  localparam int CTRL_HALT_POS = 0;
  // status bits: [0] wake, [1] falling edge seen on a selected port a pin
  localparam int ST_WAKE_POS = 0;
  localparam int ST_FALL_POS = 1;
  // ahb htrans nonseq bit
  localparam int HTRANS_NONSEQ_POS = 1;
  // port widths and synchroniser stage count
  localparam int PORT_W = 8;
  localparam int PORTF_W = 3;
  localparam int SYNC_STAGES = 2;
endpackage : gpio_pkg

// ---- gpio_sync_if.sv ----
// interface: raw pin bundle into the synchroniser and clean levels out
`timescale 1ns/100ps
`default_nettype none
interface gpio_sync_if #(parameter int W = 35);
  logic [W-1:0] raw; // straight from the pins
  logic [W-1:0] clean; // after two flops
  modport src (output raw, input clean);
  modport sync (input raw, output clean);
endinterface : gpio_sync_if
`default_nettype wire

// ---- gpio_sync.sv ----
// module: two-stage synchroniser for all pin inputs, one generate per bit
`timescale 1ns/100ps
`default_nettype none
module gpio_sync #(
  parameter int W = 35
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  gpio_sync_if.sync s
);
  genvar g;
  // per-bit two flop chain; first flop feeds only the second
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta; // first stage, read by second only
      logic held; // second stage
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta <= 1'b1;
          held <= 1'b1;
        end else if (ce_i) begin
          meta <= s.raw[g];
          held <= meta;
        end
      end
      assign s.clean[g] = held;
    end
  endgenerate
endmodule : gpio_sync
`default_nettype wire

// ---- gpio_port_top.sv ----
// top: gpio ports a,b,c,d,f with wake-up, pwm share, analog share and ahb-lite registers
`timescale 1ns/100ps
`default_nettype none
module gpio_port_top
  import gpio_pkg::*;
#(
  parameter logic [7:0] PULLUP_A = 8'hff, // fixed pull-up option per pin
  parameter logic [7:0] PULLUP_B = 8'hff,
  parameter logic [7:0] PULLUP_C = 8'hff,
  parameter logic [7:0] PULLUP_D = 8'hff,
  parameter logic [2:0] PULLUP_F = 3'h7,
  parameter bit PWM_OPTION = 1'b0 // fixed pwm-on-pin-d0 option
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // pins, four signals each: input, output, output enable, pull-up
  input wire logic [7:0] pa_in_i,
  output logic [7:0] port_a_out_o,
  output logic [7:0] port_a_oe_o,
  output logic [7:0] port_a_pu_o,
  input wire logic [7:0] pb_in_i,
  output logic [7:0] port_b_out_o,
  output logic [7:0] port_b_oe_o,
  output logic [7:0] port_b_pu_o,
  input wire logic [7:0] pc_in_i,
  output logic [7:0] port_c_out_o,
  output logic [7:0] port_c_oe_o,
  output logic [7:0] port_c_pu_o,
  input wire logic [7:0] pd_in_i,
  output logic [7:0] port_d_out_o,
  output logic [7:0] port_d_oe_o,
  output logic [7:0] port_d_pu_o,
  input wire logic [2:0] pf_in_i,
  output logic [2:0] port_f_out_o,
  output logic [2:0] port_f_oe_o,
  output logic [2:0] port_f_pu_o,
  // pwm from the pwm generator, same clock
  input wire logic pwm_i,
  // power-down and wake
  output logic power_down_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  localparam int NREG = 10; // five data, five direction
  logic [7:0] regs [NREG]; // even index data, odd index direction
  logic [7:0] wake_sel; // per-pin wake enable on port a
  logic [15:0] analog_sel; // analog select, b in [7:0], c in [15:8]
  logic [7:0] irq_status; // sticky events
  logic [7:0] irq_mask; // enables
  logic halted; // power-down state

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser
  gpio_sync_if #(.W(35)) sif ();
  assign sif.raw = {pf_in_i, pd_in_i, pc_in_i, pb_in_i, pa_in_i};
  gpio_sync #(.W(35)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .s(sif.sync)
  );
  logic [7:0] pin_lvl [5]; // clean pin levels per port
  assign pin_lvl = '{sif.clean[7:0], sif.clean[15:8], sif.clean[23:16], sif.clean[31:24],
                     {5'h00, sif.clean[34:32]}};

  ////////////////////////////////////////////////////////////////////////////
  // read value per port: latch for outputs, live pin for inputs
  logic [7:0] port_rd [5];
  logic [7:0] dig_off [5]; // pins taken by analog function
  assign dig_off = '{8'h00, analog_sel[7:0], analog_sel[15:8], 8'h00, 8'h00};
  genvar p;
  generate
    for (p = 0; p < 5; p++) begin : g_rd
      // input pins read live level at the read, output pins read latch
      assign port_rd[p] = ((regs[2*p+1] & pin_lvl[p])
                         | (~regs[2*p+1] & regs[2*p]))
                         & ~dig_off[p];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // ahb address phase capture
  logic dp_valid; // data phase pending
  logic dp_write;
  logic [7:0] dp_addr;
  wire take = hsel_i & hready_i & htrans_i[HTRANS_NONSEQ_POS];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else if (ce_i) begin
      if (hready_i) begin
        dp_valid <= take;
        dp_write <= hwrite_i;
        dp_addr <= haddr_i[7:0];
      end
    end
  end
  wire wr = dp_valid & dp_write;

  ////////////////////////////////////////////////////////////////////////////
  // bit-op decode: single bit set/clear on any port register
  wire [2:0] bo_bit = hwdata_i[BITOP_BIT_LSB +: 3];
  wire [3:0] bo_reg = hwdata_i[BITOP_REG_LSB +: 4];
  wire bo_set = hwdata_i[BITOP_SET_POS];
  wire bo_go = wr & (dp_addr == OFF_BITOP) & (bo_reg < 4'(NREG));
  // read-modify-write: whole port (or direction register) read back, bit changed, full value written
  logic [7:0] bo_old;
  logic [7:0] bo_new;
  always_comb begin
    if (bo_reg[0] == 1'b0) begin
      bo_old = port_rd[bo_reg[3:1]]; // data reg reads the port
    end else begin
      bo_old = regs[bo_reg]; // direction reads itself
    end
    bo_new = bo_old;
    bo_new[bo_bit] = bo_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // port data/direction registers
  genvar r;
  generate
    for (r = 0; r < NREG; r++) begin : g_reg
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          regs[r] <= PORT_RESET;
        end else if (ce_i) begin
          if (wr && dp_addr == 8'(4 * r)) begin
            regs[r] <= hwdata_i[7:0]; // a write here or a bit-op below changes it
          end else if (bo_go && bo_reg == 4'(r)) begin
            regs[r] <= bo_new;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // wake select, analog select, mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_sel <= WAKE_RESET;
      analog_sel <= ANALOG_RESET;
      irq_mask <= STATUS_RESET;
    end else if (ce_i && wr) begin
      if (dp_addr == OFF_WAKE_SEL) begin
        wake_sel <= hwdata_i[7:0];
      end
      if (dp_addr == OFF_ANALOG_SEL) begin
        analog_sel <= hwdata_i[15:0];
      end
      if (dp_addr == OFF_IRQ_MASK) begin
        irq_mask <= hwdata_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake detection on port a falling edges
  logic [7:0] pa_prev; // last clean level, reads clean output only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_prev <= PORT_RESET;
    end else if (ce_i) begin
      pa_prev <= pin_lvl[0];
    end
  end
  wire [7:0] pa_fall = pa_prev & ~pin_lvl[0] & wake_sel;
  wire wake_ev = halted & (|pa_fall);

  // halt: software write enters power-down; the core clock gate follows power_down_o
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halted <= 1'b0;
    end else if (ce_i) begin
      if (wake_ev) begin
        halted <= 1'b0;
      end else if (wr && dp_addr == OFF_CTRL && hwdata_i[CTRL_HALT_POS]) begin
        halted <= 1'b1;
      end
    end
  end

  // sticky status; a new event wins over a write-one clear
  logic [7:0] ev;
  always_comb begin
    ev = 8'h00;
    ev[ST_WAKE_POS] = wake_ev;
    ev[ST_FALL_POS] = |pa_fall;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= STATUS_RESET;
    end else if (ce_i) begin
      if (wr && dp_addr == OFF_IRQ_STATUS) begin
        irq_status <= (irq_status & ~hwdata_i[7:0]) | ev;
      end else begin
        irq_status <= irq_status | ev;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, combinational on the data phase address
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (dp_addr)
      OFF_A_DATA: rd_val[7:0] = port_rd[0];
      OFF_A_DIR: rd_val[7:0] = regs[1];
      OFF_B_DATA: rd_val[7:0] = port_rd[1];
      OFF_B_DIR: rd_val[7:0] = regs[3];
      OFF_C_DATA: rd_val[7:0] = port_rd[2];
      OFF_C_DIR: rd_val[7:0] = regs[5];
      OFF_D_DATA: rd_val[7:0] = port_rd[3];
      OFF_D_DIR: rd_val[7:0] = regs[7];
      OFF_F_DATA: rd_val[PORTF_W-1:0] = port_rd[4][PORTF_W-1:0]; // three pins only
      OFF_F_DIR: rd_val[PORTF_W-1:0] = regs[9][PORTF_W-1:0]; // upper bits read zero
      OFF_WAKE_SEL: rd_val[7:0] = wake_sel;
      OFF_ANALOG_SEL: rd_val[15:0] = analog_sel;
      OFF_CTRL: rd_val[0] = halted;
      OFF_IRQ_STATUS: rd_val[7:0] = irq_status;
      OFF_IRQ_MASK: rd_val[7:0] = irq_mask;
      default: rd_val = 32'h0000_0000; // unmapped reads zero
    endcase
  end
  // registered read: one wait state so hrdata comes from a flop
  logic rd_wait;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_wait <= 1'b0;
      hreadyout_o <= 1'b1;
      hrdata_o <= 32'h0000_0000;
      hresp_o <= 1'b0;
    end else if (ce_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0; // always okay
      rd_wait <= 1'b0;
      if (take && !hwrite_i) begin
        hreadyout_o <= 1'b0; // stall one cycle
        rd_wait <= 1'b1;
      end else if (rd_wait) begin
        hrdata_o <= rd_val; // pins sampled at the read
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers, registered
  logic [7:0] drv_oe [5];
  logic [7:0] drv_out [5];
  logic [7:0] drv_pu [5];
  localparam logic [7:0] PU_OPT [5] = '{PULLUP_A, PULLUP_B, PULLUP_C, PULLUP_D,
                                       {5'h00, PULLUP_F}};
  generate
    for (p = 0; p < 5; p++) begin : g_pin
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          drv_oe[p] <= 8'h00;
          drv_out[p] <= PORT_RESET;
          drv_pu[p] <= 8'h00;
        end else if (ce_i) begin
          drv_oe[p] <= ~regs[2*p+1] & ~dig_off[p];
          drv_out[p] <= regs[2*p];
          drv_pu[p] <= regs[2*p+1] & PU_OPT[p] & ~dig_off[p];
          if (p == 3 && PWM_OPTION && !regs[7][0]) begin
            drv_out[p][0] <= pwm_i; // option fixed at build
          end
        end
      end
    end
  endgenerate
  assign port_a_out_o = drv_out[0];
  assign port_a_oe_o = drv_oe[0];
  assign port_a_pu_o = drv_pu[0];
  assign port_b_out_o = drv_out[1];
  assign port_b_oe_o = drv_oe[1];
  assign port_b_pu_o = drv_pu[1];
  assign port_c_out_o = drv_out[2];
  assign port_c_oe_o = drv_oe[2];
  assign port_c_pu_o = drv_pu[2];
  assign port_d_out_o = drv_out[3];
  assign port_d_oe_o = drv_oe[3];
  assign port_d_pu_o = drv_pu[3];
  assign port_f_out_o = drv_out[4][2:0];
  assign port_f_oe_o = drv_oe[4][2:0];
  assign port_f_pu_o = drv_pu[4][2:0];

  // power-down flag and interrupt level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_down_o <= 1'b0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      power_down_o <= halted;
      irq_o <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_RESET_DIR: assert property (@(posedge clk_i) rst_i |=> regs[1] == 8'hff)
    else $error("direction not all ones after reset");
  AST_OUT_DRV: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !regs[3][0] && !analog_sel[0] |=> port_b_oe_o[0])
    else $error("output pin not driven");
  AST_IN_FLOAT: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && regs[1][2] |=> !port_a_oe_o[2])
    else $error("input pin driven");
  AST_RD_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
    !regs[1][0] |-> port_rd[0][0] == regs[0][0])
    else $error("output read not latch");
  AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !(dp_valid && dp_write) |=> $stable(regs[0]))
    else $error("latch changed without write");
  AST_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && halted && |pa_fall |=> !halted)
    else $error("no wake on selected fall");
  AST_NO_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && halted && (pa_prev & ~pin_lvl[0] & wake_sel) == 8'h00 |=> halted)
    else $error("woke without selected fall");
  AST_PU_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !regs[5][1] |=> !port_c_pu_o[1])
    else $error("pull-up on output pin");
  AST_ANALOG: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && analog_sel[9] |=> !port_c_oe_o[1] && !port_c_pu_o[1])
    else $error("analog pin still digital");
  AST_PWM: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && regs[7][0] |=> !port_d_oe_o[0])
    else $error("pwm pin driven as input");
  AST_HALT: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && halted |=> power_down_o)
    else $error("power-down not shown");
endmodule : gpio_port_top
`default_nettype wire

// ---- pin_board.sv ----
// pin_board: switches and loads on one port's pins
`timescale 1ns/100ps
`default_nettype none
module pin_board #(
  parameter int W = 8
) (
  input wire logic [W-1:0] out_i, // device drive value
  input wire logic [W-1:0] oe_i, // high while device drives
  input wire logic [W-1:0] ext_i, // switch levels
  input wire logic [W-1:0] short_i, // pins shorted to ground
  output logic [W-1:0] pin_o // level seen at the pin
);
  // a short beats the device drive, so readback can differ from the wire
  assign pin_o = (oe_i & out_i | ~oe_i & ext_i) & ~short_i;
endmodule : pin_board
`default_nettype wire

// ---- tb.sv ----
// tb: self-checking bench for the gpio port block
`timescale 1ns/100ps
`default_nettype none
module tb import gpio_pkg::*;;
  localparam logic [7:0] PU_B = 8'h3c; // partial pull-up option
  logic clk_i, rst_i, hwrite_i, pwm_i, hreadyout_o, hresp, power_down_o, irq_o, rd_ph, ce;
  logic [1:0] htrans_i;
  logic [2:0] hsize_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [7:0] pout [5], poe [5], ppu [5], ext [5], pin [5], short_m;
  logic [31:0] exp_q [$]; // expected read data, oldest first
  int error_cnt, n_checks;
  ////////////////////////////////////////////////////////////////////////////
  gpio_port_top #(.PULLUP_B(PU_B), .PWM_OPTION(1'b1)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .hsel_i(1'b1), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp), .pa_in_i(pin[0]), .port_a_out_o(pout[0]), .port_a_oe_o(poe[0]),
    .port_a_pu_o(ppu[0]), .pb_in_i(pin[1]), .port_b_out_o(pout[1]),
    .port_b_oe_o(poe[1]), .port_b_pu_o(ppu[1]), .pc_in_i(pin[2]),
    .port_c_out_o(pout[2]), .port_c_oe_o(poe[2]), .port_c_pu_o(ppu[2]),
    .pd_in_i(pin[3]), .port_d_out_o(pout[3]), .port_d_oe_o(poe[3]),
    .port_d_pu_o(ppu[3]), .pf_in_i(pin[4][2:0]), .port_f_out_o(pout[4][2:0]),
    .port_f_oe_o(poe[4][2:0]), .port_f_pu_o(ppu[4][2:0]), .pwm_i(pwm_i),
    .power_down_o(power_down_o), .irq_o(irq_o)
  );
  // one board model per port; only port a can be shorted
  for (genvar p = 0; p < 5; p++) begin : g_brd
    pin_board #(.W(8)) u_brd (.out_i(pout[p]), .oe_i(poe[p]), .ext_i(ext[p]),
      .short_i(p == 0 ? short_m : 8'h00), .pin_o(pin[p]));
  end
  ////////////////////////////////////////////////////////////////////////////
  // free-running system clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // wait for hready sampled high, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) begin
      n++;
      if (n > 40) begin
        error_cnt++;
        summarize();
      end
      @(posedge clk_i);
    end
  endtask : wait_rdy
  // one single ahb-lite transfer, address phase then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    htrans_i <= 2'b10;
    wait_rdy();
    htrans_i <= 2'b00;
    hwdata_i <= d;
    wait_rdy();
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  // read: note the expectation, the monitor compares
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask : rd
  // sync stages plus edge detect and output flop
  task automatic settle();
    repeat (SYNC_STAGES + 2) @(posedge clk_i);
  endtask : settle
  function automatic logic [7:0] msk(input int p);
    return (p == 4) ? 8'h07 : 8'hff;
  endfunction : msk
  ////////////////////////////////////////////////////////////////////////////
  // monitor: read data taken at the edge that ends the data phase
  always @(posedge clk_i) begin
    if (rd_ph && hreadyout_o === 1'b1) check(hrdata_o, exp_q.pop_front());
    if (hreadyout_o === 1'b1) rd_ph <= htrans_i[1] && !hwrite_i;
    if (rst_i) rd_ph <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int p, n;
    logic [7:0] dv, lv, e, m, dm;
    logic [31:0] w;
    rst_i = 1'b1;
    htrans_i = 2'b00;
    haddr_i = 32'h0;
    hwrite_i = 1'b0;
    hwdata_i = 32'h0;
    hsize_i = 3'h2;
    pwm_i = 1'b0;
    short_m = 8'h00;
    rd_ph = 1'b0;
    ce = 1'b1;
    for (p = 0; p < 5; p++) ext[p] = 8'hff;
    void'($urandom(32'h0817b9f3));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    // all ports inputs, direction registers read all ones
    for (p = 0; p < 5; p++) begin
      check(poe[p] & msk(p), 32'h0);
      rd(8'(8 * p + 4), {24'h0, msk(p)});
    end
    check(hresp, 1'b0);
    // direction to output without data write: drives high
    wr(OFF_A_DIR, 32'h0);
    short_m <= 8'h0f;
    settle();
    check(pout[0], 8'hff);
    check(poe[0], 8'hff);
    rd(OFF_A_DATA, 32'hff);
    short_m <= 8'h00;
    // random mixes of direction, latch and pin levels on every port
    for (int i = 0; i < 15; i++) begin
      p = i % 5;
      m = msk(p);
      w = $urandom;
      dv = w[7:0];
      wr(8'(8 * p + 4), w);
      w = $urandom;
      lv = w[7:0];
      wr(8'(8 * p), w);
      e = 8'($urandom);
      ext[p] <= e;
      settle();
      check(poe[p] & m, ~dv & m);
      // d0 carries pwm when output, so it is left out here
      dm = m & ~dv & (p == 3 ? 8'hfe : 8'hff);
      check(pout[p] & dm, lv & dm);
      check(ppu[p] & m, dv & m & (p == 1 ? PU_B : 8'hff));
      rd(8'(8 * p), {24'h0, (lv & ~dv | e & dv) & m});
    end
    // bit set/clear reads the whole port, pins included
    ext[0] <= 8'hff;
    wr(OFF_A_DIR, 32'h0f);
    wr(OFF_A_DATA, 32'h0);
    settle();
    wr(OFF_BITOP, 32'h104);
    wr(OFF_A_DIR, 32'h0);
    settle();
    check(pout[0], 8'h1f);
    wr(OFF_BITOP, 32'h000);
    wr(OFF_BITOP, 32'h10a);
    settle();
    check(pout[0], 8'h1e);
    check(poe[0], 8'hfb);
    // analog select takes pins away from digital use
    wr(OFF_B_DIR, 32'h0);
    wr(OFF_C_DIR, 32'hff);
    wr(OFF_ANALOG_SEL, 32'h8001);
    settle();
    check(poe[1], 8'hfe);
    check(ppu[2], 8'h7f);
    wr(OFF_ANALOG_SEL, 32'h0);
    // pwm on d0 only while d0 is an output
    wr(OFF_D_DIR, 32'hfe);
    for (n = 0; n < 2; n++) begin
      pwm_i <= ~n[0];
      settle();
      check(pout[3][0], {31'h0, ~n[0]});
    end
    wr(OFF_D_DIR, 32'hff);
    settle();
    check(poe[3][0], 1'b0);
    check(ppu[3][0], 1'b1);
    // wake-up on a selected port a pin only
    wr(OFF_A_DIR, 32'hff);
    wr(OFF_IRQ_MASK, 32'h3);
    // pa5 is the only selected wake pin here; pa4 stays unselected
    wr(OFF_WAKE_SEL, 32'h20);
    wr(OFF_IRQ_STATUS, 32'h3);
    ext[0] <= 8'hef;
    settle();
    rd(OFF_IRQ_STATUS, 32'h0);
    check(irq_o, 1'b0);
    ext[0] <= 8'hff;
    wr(OFF_CTRL, 32'h1);
    settle();
    check(power_down_o, 1'b1);
    // an unselected pin falls first and must not wake
    ext[0] <= 8'hef;
    settle();
    check(power_down_o, 1'b1);
    ext[0] <= 8'hcf;
    for (n = 0; n < 20 && power_down_o !== 1'b0; n++) @(posedge clk_i);
    check(power_down_o, 1'b0);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b1);
    rd(OFF_IRQ_STATUS, 32'h3);
    // mask and write-one-to-clear
    wr(OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b0);
    wr(OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b1);
    wr(OFF_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b0);
    rd(OFF_IRQ_STATUS, 32'h2);
    wr(OFF_IRQ_STATUS, 32'h2);
    rd(OFF_IRQ_STATUS, 32'h0);
    // unmapped place reads zero, writes ignored
    rd(8'h40, 32'h0);
    wr(8'h40, $urandom);
    rd(OFF_A_DIR, 32'hff);
    // clock enable low freezes the synchronisers, so a pulse while frozen is never seen
    ce <= 1'b0;
    ext[0] <= 8'hff;
    repeat (4) @(posedge clk_i);
    ext[0] <= 8'hcf;
    repeat (4) @(posedge clk_i);
    ce <= 1'b1;
    settle();
    rd(OFF_IRQ_STATUS, 32'h0);
    repeat (2) @(posedge clk_i);
    summarize();
  end
endmodule : tb
`default_nettype wire
